// [include/smvs_pkg.sv]
// Shared constants, types and helpers for the safe-mode valve supervisor.
// Assumes one clock domain and a plain strobe register port.
`default_nettype none

package smvs_pkg;

    // ==========================================================
    // Widths
    localparam int AW = 4;
    localparam int DW = 16;
    localparam int TW = 8;

    // ==========================================================
    // Register offsets
    localparam logic [AW-1:0] REG_CTRL        = 4'h0;
    localparam logic [AW-1:0] REG_STATUS      = 4'h1;
    localparam logic [AW-1:0] REG_SAFE_STATE  = 4'h2;
    localparam logic [AW-1:0] REG_SAFE_VALUE  = 4'h3;
    localparam logic [AW-1:0] REG_OVERRIDE    = 4'h4;
    localparam logic [AW-1:0] REG_PRESS_DTYPE = 4'h5;
    localparam logic [AW-1:0] REG_FLOW_DTYPE  = 4'h6;
    localparam logic [AW-1:0] REG_VALVE_DTYPE = 4'h7;
    localparam logic [AW-1:0] REG_FLOW_CAL    = 4'h8;
    localparam logic [AW-1:0] REG_PRESS_APP   = 4'h9;
    localparam logic [AW-1:0] REG_FULL_SCALE  = 4'hA;
    localparam logic [AW-1:0] REG_REJECT      = 4'hB;
    localparam logic [AW-1:0] REG_SETPOINT    = 4'hC;

    // Field positions
    localparam int CTRL_RUN_BIT  = 0;
    localparam int CTRL_STOP_BIT = 1;
    localparam int CTRL_FCLR_BIT = 2;
    localparam int REJECT_BIT    = 0;

    // ==========================================================
    // Codes and reset values
    localparam logic [TW-1:0] DT_INT         = 8'h01;
    localparam logic [TW-1:0] DT_REAL        = 8'h02;
    localparam logic [TW-1:0] RST_DTYPE      = 8'h01;
    localparam logic [TW-1:0] FLOW_CAL_MIN   = 8'h01;
    localparam logic [TW-1:0] FLOW_CAL_MAX   = 8'h06;
    localparam logic [TW-1:0] RST_FLOW_CAL   = 8'h01;
    localparam logic [TW-1:0] RST_PRESS_APP  = 8'h01;
    localparam logic [DW-1:0] RST_FULL_SCALE = 16'h6000;
    localparam logic [DW-1:0] RST_SAFE_VALUE = 16'h0000;
    localparam logic [DW-1:0] VALVE_CLOSED   = 16'h0000;
    localparam logic [DW-1:0] PRESS_SAT_MAX  = 16'h7FFF;
    localparam logic [DW-1:0] PRESS_SAT_MIN  = 16'h8000;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_EXEC  = 2'b01,
        ST_FAULT = 2'b10
    } smvs_state_t;

    typedef enum logic [1:0] {
        SAFE_CLOSED = 2'b00,
        SAFE_OPEN   = 2'b01,
        SAFE_HOLD   = 2'b10,
        SAFE_VALUE  = 2'b11
    } smvs_safe_t;

    typedef enum logic [2:0] {
        OVR_NORMAL = 3'b000,
        OVR_CLOSED = 3'b001,
        OVR_OPEN   = 3'b010,
        OVR_HOLD   = 3'b011,
        OVR_SAFE   = 3'b100
    } smvs_ovr_t;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } smvs_bus_t;

    typedef struct packed {
        logic          conn_open;
        logic          data_valid;
        logic [TW-1:0] data_len;
        logic          expected_packet_rate_timeout;
    } smvs_io_t;

    typedef struct packed {
        logic          press_hit;
        logic [TW-1:0] press_type;
        logic          flow_hit;
        logic [TW-1:0] flow_type;
        logic          valve_hit;
        logic [TW-1:0] valve_type;
    } smvs_infer_t;

    function automatic logic dtype_ok(input logic [DW-1:0] v);
        dtype_ok = (v == {8'h00, DT_INT}) || (v == {8'h00, DT_REAL});
    endfunction : dtype_ok

endpackage : smvs_pkg

`default_nettype wire

// [src/smvs_valve_sel.sv]
// Valve command selector: controller, override or safe-state source.
// Pure combinational; the caller registers the result.
`timescale 1ns/1ps
`default_nettype none

module smvs_valve_sel
    import smvs_pkg::*;
(
    input  wire logic          exec_i,
    input  wire smvs_safe_t    safe_i,
    input  wire smvs_ovr_t     ovr_i,
    input  wire logic [DW-1:0] ctrl_i,
    input  wire logic [DW-1:0] safe_value_i,
    input  wire logic [DW-1:0] full_scale_i,
    input  wire logic [DW-1:0] last_i,
    output logic      [DW-1:0] cmd_o
);

    logic [DW-1:0] safe_cmd;

    // ==========================================================
    // Safe-state source
    always_comb begin
        unique case (safe_i)
            SAFE_CLOSED: safe_cmd = VALVE_CLOSED;
            SAFE_OPEN:   safe_cmd = full_scale_i;
            SAFE_HOLD:   safe_cmd = last_i;
            SAFE_VALUE:  safe_cmd = safe_value_i;
        endcase
    end

    // ==========================================================
    // Override only counts while executing
    always_comb begin
        if (!exec_i) begin
            cmd_o = safe_cmd;
        end else begin
            unique case (ovr_i)
                OVR_NORMAL: cmd_o = ctrl_i;
                OVR_CLOSED: cmd_o = VALVE_CLOSED;
                OVR_OPEN:   cmd_o = full_scale_i;
                OVR_HOLD:   cmd_o = last_i;
                OVR_SAFE:   cmd_o = safe_cmd;
                default:    cmd_o = ctrl_i;
            endcase
        end
    end

endmodule : smvs_valve_sel

`default_nettype wire

// [src/smvs_press_sat.sv]
// Pressure reporter: clamps a wide linearised reading into 16-bit counts.
// Assumes the sensing path already applied the selected calibration.
`timescale 1ns/1ps
`default_nettype none

module smvs_press_sat
    import smvs_pkg::*;
#(
    parameter int IW = 24
) (
    input  wire logic signed [IW-1:0] raw_i,
    output logic             [DW-1:0] counts_o
);

    localparam logic signed [IW-1:0] HI = IW'(signed'(PRESS_SAT_MAX));
    localparam logic signed [IW-1:0] LO = IW'(signed'(PRESS_SAT_MIN));

    // ==========================================================
    // Signed 16-bit cannot show anything past its top count
    always_comb begin
        if (raw_i > HI) begin
            counts_o = PRESS_SAT_MAX;
        end else if (raw_i < LO) begin
            counts_o = PRESS_SAT_MIN;
        end else begin
            counts_o = raw_i[DW-1:0];
        end
    end

endmodule : smvs_press_sat

`default_nettype wire

// [src/smvs_top.sv]
// Safe-mode valve supervisor: run state, valve command, data-type gating.
// Assumes a single 250 MHz clock and a synchronous strobe register port.
//
// Local design decisions: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Safe mode in every state except executing.
// - Safe mode halts control, ignores setpoints and override commands.
// - Enter executing on I/O data exchange or a run directive.
// - Leave executing on all connections closed, rate timeout, or directive.
// - Leave executing by itself on a severe fault.
// - Safe-state codes: 0 closed (default), 1 open, 2 hold, 3 safe value.
// - In safe mode drive the valve per the current safe-state code.
// - An override replaces the controller valve command.
// - Override acts only while executing.
// - Data-type writes accepted only when idle and not polled.
// - On I/O start force data types to the assembly's inferred type.
// - Data types accept only 16-bit integer and 32-bit float codes.
// - Flow calibration selector accepts 1 to 6 only.
// - Pressure application selector accepts 1 up to installed count.
// - Pressure counts saturate at the 16-bit signed top value.
// - Data types read-only while any I/O connection is open.
// - Hold drives last command; closed is zero, open is full scale.
// - Override codes: 0 normal, 1 closed, 2 open, 3 hold, 4 safe state.
module smvs_top
    import smvs_pkg::*;
#(
    parameter int NUM_PRESS_APPS = 4,
    parameter int RAW_W          = 24
) (
    input  wire logic                    clock_i,
    input  wire logic                    reset_n_i,
    input  wire smvs_bus_t               bus_i,
    output logic             [DW-1:0]    rdata_o,
    input  wire smvs_io_t                io_i,
    input  wire smvs_infer_t             infer_i,
    input  wire logic                    severe_fault_i,
    input  wire logic        [DW-1:0]    ctrl_valve_i,
    input  wire logic signed [RAW_W-1:0] press_raw_i,
    output logic             [DW-1:0]    valve_cmd_o,
    output logic                         safe_mode_o,
    output logic                         ctrl_run_o,
    output logic             [DW-1:0]    setpoint_o,
    output logic             [DW-1:0]    press_o,
    output logic             [TW-1:0]    press_app_o,
    output logic             [TW-1:0]    flow_cal_o,
    output logic             [TW-1:0]    press_dtype_o,
    output logic             [TW-1:0]    flow_dtype_o,
    output logic             [TW-1:0]    valve_dtype_o,
    output logic                         reject_o
);

    localparam logic [TW-1:0] APP_MAX = TW'(NUM_PRESS_APPS);

    smvs_state_t   state;
    smvs_state_t   next_state;
    smvs_safe_t    safe_sel;
    smvs_ovr_t     ovr_sel;
    logic [DW-1:0] safe_value;
    logic [DW-1:0] full_scale;
    logic [DW-1:0] last_cmd;
    logic [DW-1:0] next_cmd;
    logic [DW-1:0] sat_counts;
    logic          conn_prev;
    logic          io_active;

    // ==========================================================
    // Decode
    logic wr;
    logic exec;
    logic io_start;
    logic conn_fall;
    logic run_cmd;
    logic stop_cmd;
    logic fclr_cmd;
    logic dtype_open;
    logic wr_dtype;
    logic bad_write;

    assign wr        = bus_i.wr;
    assign exec      = (state == ST_EXEC);
    assign io_start  = io_i.conn_open && io_i.data_valid && (io_i.data_len != 8'h00);
    assign conn_fall = conn_prev && !io_i.conn_open;
    assign run_cmd   = wr && (bus_i.addr == REG_CTRL) && bus_i.wdata[CTRL_RUN_BIT];
    assign stop_cmd  = wr && (bus_i.addr == REG_CTRL) && bus_i.wdata[CTRL_STOP_BIT];
    assign fclr_cmd  = wr && (bus_i.addr == REG_CTRL) && bus_i.wdata[CTRL_FCLR_BIT];
    assign wr_dtype  = wr && ((bus_i.addr == REG_PRESS_DTYPE)
                           || (bus_i.addr == REG_FLOW_DTYPE)
                           || (bus_i.addr == REG_VALVE_DTYPE));
    // Polled or connected means the types are locked
    assign dtype_open = (state == ST_IDLE) && !io_i.conn_open;

    // ==========================================================
    // Supervisory state
    always_comb begin
        next_state = state;
        if (severe_fault_i) begin
            next_state = ST_FAULT;
        end else begin
            unique case (state)
                ST_IDLE:  if (io_start || run_cmd) next_state = ST_EXEC;
                ST_EXEC:  if (conn_fall || io_i.expected_packet_rate_timeout || stop_cmd)
                              next_state = ST_IDLE;
                ST_FAULT: if (fclr_cmd) next_state = ST_IDLE;
                default:  next_state = ST_FAULT;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state       <= ST_IDLE;
            safe_mode_o <= 1'b1;
            ctrl_run_o  <= 1'b0;
        end else begin
            state       <= next_state;
            safe_mode_o <= (next_state != ST_EXEC);
            ctrl_run_o  <= (next_state == ST_EXEC);
        end
    end

    // ==========================================================
    // Connection tracking
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            conn_prev <= 1'b0;
            io_active <= 1'b0;
        end else begin
            conn_prev <= io_i.conn_open;
            if (!io_i.conn_open) begin
                io_active <= 1'b0;
            end else if (io_start) begin
                io_active <= 1'b1;
            end
        end
    end

    // ==========================================================
    // Data types: forcing on I/O start beats a software write
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            press_dtype_o <= RST_DTYPE;
            flow_dtype_o  <= RST_DTYPE;
            valve_dtype_o <= RST_DTYPE;
        end else if (io_start && !io_active) begin
            if (infer_i.press_hit) press_dtype_o <= infer_i.press_type;
            if (infer_i.flow_hit)  flow_dtype_o  <= infer_i.flow_type;
            if (infer_i.valve_hit) valve_dtype_o <= infer_i.valve_type;
        end else if (wr_dtype && dtype_open && dtype_ok(bus_i.wdata)) begin
            unique case (bus_i.addr)
                REG_PRESS_DTYPE: press_dtype_o <= bus_i.wdata[TW-1:0];
                REG_FLOW_DTYPE:  flow_dtype_o  <= bus_i.wdata[TW-1:0];
                default:         valve_dtype_o <= bus_i.wdata[TW-1:0];
            endcase
        end
    end

    // ==========================================================
    // Valve and sensor configuration
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            safe_sel    <= SAFE_CLOSED;
            safe_value  <= RST_SAFE_VALUE;
            full_scale  <= RST_FULL_SCALE;
            ovr_sel     <= OVR_NORMAL;
            flow_cal_o  <= RST_FLOW_CAL;
            press_app_o <= RST_PRESS_APP;
            setpoint_o  <= 16'h0000;
        end else if (wr) begin
            unique case (bus_i.addr)
                REG_SAFE_STATE: safe_sel   <= smvs_safe_t'(bus_i.wdata[1:0]);
                REG_SAFE_VALUE: safe_value <= bus_i.wdata;
                REG_FULL_SCALE: full_scale <= bus_i.wdata;
                // Commands arriving in safe mode are dropped, not queued
                REG_OVERRIDE: if (exec && (bus_i.wdata <= 16'h0004))
                    ovr_sel <= smvs_ovr_t'(bus_i.wdata[2:0]);
                REG_FLOW_CAL: if ((bus_i.wdata >= {8'h00, FLOW_CAL_MIN})
                                  && (bus_i.wdata <= {8'h00, FLOW_CAL_MAX}))
                    flow_cal_o <= bus_i.wdata[TW-1:0];
                REG_PRESS_APP: if ((bus_i.wdata != 16'h0000) && (bus_i.wdata <= {8'h00, APP_MAX}))
                    press_app_o <= bus_i.wdata[TW-1:0];
                REG_SETPOINT: if (exec) setpoint_o <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // ==========================================================
    // Rejected writes: set wins over the clear in the same cycle
    always_comb begin
        bad_write = 1'b0;
        if (wr) begin
            unique case (bus_i.addr)
                REG_PRESS_DTYPE,
                REG_FLOW_DTYPE,
                REG_VALVE_DTYPE: bad_write = !dtype_open || !dtype_ok(bus_i.wdata);
                REG_OVERRIDE:    bad_write = !exec || (bus_i.wdata > 16'h0004);
                REG_FLOW_CAL:    bad_write = (bus_i.wdata < {8'h00, FLOW_CAL_MIN})
                                          || (bus_i.wdata > {8'h00, FLOW_CAL_MAX});
                REG_PRESS_APP:   bad_write = (bus_i.wdata == 16'h0000)
                                          || (bus_i.wdata > {8'h00, APP_MAX});
                default:         bad_write = 1'b0;
            endcase
        end
    end

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            reject_o <= 1'b0;
        end else if (bad_write) begin
            reject_o <= 1'b1;
        end else if (wr && (bus_i.addr == REG_REJECT) && bus_i.wdata[REJECT_BIT]) begin
            reject_o <= 1'b0;
        end
    end

    // ==========================================================
    // Valve command path
    smvs_valve_sel u_valve_sel (
        .exec_i       (exec),
        .safe_i       (safe_sel),
        .ovr_i        (ovr_sel),
        .ctrl_i       (ctrl_valve_i),
        .safe_value_i (safe_value),
        .full_scale_i (full_scale),
        .last_i       (last_cmd),
        .cmd_o        (next_cmd)
    );

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            valve_cmd_o <= VALVE_CLOSED;
            last_cmd    <= VALVE_CLOSED;
        end else begin
            valve_cmd_o <= next_cmd;
            if (exec) begin
                last_cmd <= next_cmd;
            end
        end
    end

    // ==========================================================
    // Pressure reporting
    smvs_press_sat #(.IW(RAW_W)) u_press_sat (
        .raw_i    (press_raw_i),
        .counts_o (sat_counts)
    );

    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            press_o <= 16'h0000;
        end else begin
            press_o <= sat_counts;
        end
    end

    // ==========================================================
    // Read port: data stand one cycle after the strobe
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rdata_o <= 16'h0000;
        end else if (bus_i.rd) begin
            unique case (bus_i.addr)
                REG_STATUS:      rdata_o <= {12'h000, io_active, safe_mode_o, state};
                REG_SAFE_STATE:  rdata_o <= {14'h0000, safe_sel};
                REG_SAFE_VALUE:  rdata_o <= safe_value;
                REG_OVERRIDE:    rdata_o <= {13'h0000, ovr_sel};
                REG_PRESS_DTYPE: rdata_o <= {8'h00, press_dtype_o};
                REG_FLOW_DTYPE:  rdata_o <= {8'h00, flow_dtype_o};
                REG_VALVE_DTYPE: rdata_o <= {8'h00, valve_dtype_o};
                REG_FLOW_CAL:    rdata_o <= {8'h00, flow_cal_o};
                REG_PRESS_APP:   rdata_o <= {8'h00, press_app_o};
                REG_FULL_SCALE:  rdata_o <= full_scale;
                REG_REJECT:      rdata_o <= {15'h0000, reject_o};
                REG_SETPOINT:    rdata_o <= setpoint_o;
                default:         rdata_o <= 16'h0000;
            endcase
        end else begin
            rdata_o <= 16'h0000;
        end
    end

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence s_idle_run;
        (state == ST_IDLE) && run_cmd && !severe_fault_i;
    endsequence

    sequence s_io_begin;
        (state == ST_IDLE) && io_start && !severe_fault_i;
    endsequence

    a_safe_mode_flag: assert property (safe_mode_o == (state != ST_EXEC))
        else $error("safe mode flag disagrees with state");
    a_enter_exec: assert property ((s_idle_run or s_io_begin) |=> exec ##0 !safe_mode_o)
        else $error("executing not entered");
    a_leave_timeout: assert property (exec && io_i.expected_packet_rate_timeout
                                      && !severe_fault_i |=> (state == ST_IDLE))
        else $error("timeout did not leave executing");
    a_fault_entry: assert property (severe_fault_i |=> (state == ST_FAULT) [*1])
        else $error("severe fault ignored");
    a_safe_closed_out: assert property (!exec && (safe_sel == SAFE_CLOSED)
                                        |=> (valve_cmd_o == VALVE_CLOSED))
        else $error("safe closed valve not zero");
    a_override_open: assert property (exec && (ovr_sel == OVR_OPEN)
                                      |=> (valve_cmd_o == $past(full_scale)))
        else $error("open override not at full scale");
    a_override_blocked: assert property (!exec |=> $stable(ovr_sel))
        else $error("override changed outside executing");
    a_dtype_locked: assert property (wr_dtype && !dtype_open && !(io_start && !io_active)
                                     |=> $stable(press_dtype_o) && $stable(flow_dtype_o)
                                         && $stable(valve_dtype_o) && reject_o)
        else $error("data type changed while locked");
    a_dtype_range: assert property (wr_dtype && !dtype_ok(bus_i.wdata)
                                    |=> reject_o)
        else $error("bad data type not flagged");
    a_flow_cal_range: assert property ((flow_cal_o >= FLOW_CAL_MIN)
                                       && (flow_cal_o <= FLOW_CAL_MAX))
        else $error("flow calibration selector out of range");
    a_press_sat_top: assert property ($signed(press_raw_i) > $signed(RAW_W'(32767))
                                      |=> (press_o == PRESS_SAT_MAX))
        else $error("pressure not saturated");
    a_hold_keeps: assert property (!exec ##1 !exec |-> $stable(last_cmd))
        else $error("hold value moved in safe mode");

endmodule : smvs_top

`default_nettype wire

// [testbench/smvs_master_model.sv]
// Fieldbus master model: opens a link with one I/O frame, closes it or times out.
// Assumes the bench asks for each action by a one-cycle request pulse.
`timescale 1ns/1ps
`default_nettype none
module smvs_master_model
    import smvs_pkg::*;
(
    input  wire logic       clock_i,
    input  wire logic       reset_n_i,
    input  wire logic [2:0] req_i,
    output smvs_io_t        io_o
);
    // ==========
    // Link driving
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            io_o <= '0;
        end else begin
            io_o.data_valid <= req_i[0];
            // Length is zero outside frames so a stray valid never starts I/O
            io_o.data_len <= req_i[0] ? 8'h02 : 8'h00;
            io_o.expected_packet_rate_timeout <= req_i[2];
            if (req_i[0]) begin
                io_o.conn_open <= 1'b1;
            end else if (req_i[1] || req_i[2]) begin
                io_o.conn_open <= 1'b0;
            end
        end
    end
endmodule : smvs_master_model
`default_nettype wire

// [testbench/smvs_tb_top.sv]
// Bench for the supervisor: register tasks, link model, valve and state checks.
// Assumes smvs_pkg is compiled first.
`timescale 1ns/1ps
`default_nettype none
module smvs_tb_top
    import smvs_pkg::*;
;
    logic clk = 1'b0, rst_n = 1'b0, fault = 1'b0;
    logic [2:0] req = '0;
    smvs_bus_t bus = '0;
    smvs_io_t io;
    smvs_infer_t infer = '0;
    logic [DW-1:0] ctrl = 16'h1234, rdata, valve, setp, press, d;
    logic signed [23:0] raw = '0;
    logic safe, run, rej;
    logic [TW-1:0] app, fcal, pdt, fdt, vdt;
    int num_errors = 0, cmp_count = 0;
    logic [DW-1:0] exp_ovr [5] = '{16'h1234, 16'h0000, 16'h6000, 16'h6000, 16'h0000};
    logic [DW-1:0] exp_safe [4] = '{16'h0000, 16'h7FFF, 16'h1234, 16'h0ABC};

    smvs_master_model i_smvs_master_model (.clock_i(clk), .reset_n_i(rst_n), .req_i(req),
        .io_o(io));
    smvs_top i_smvs_top (.clock_i(clk), .reset_n_i(rst_n), .bus_i(bus), .rdata_o(rdata),
        .io_i(io), .infer_i(infer), .severe_fault_i(fault), .ctrl_valve_i(ctrl),
        .press_raw_i(raw), .valve_cmd_o(valve), .safe_mode_o(safe), .ctrl_run_o(run),
        .setpoint_o(setp), .press_o(press), .press_app_o(app), .flow_cal_o(fcal),
        .press_dtype_o(pdt), .flow_dtype_o(fdt), .valve_dtype_o(vdt), .reject_o(rej));

    initial begin
        forever #2 clk = ~clk;
    end

    // ==========
    // Tasks
    task automatic check(input string what, input logic [DW-1:0] seen, input logic [DW-1:0] e);
        cmp_count++;
        if (seen !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, seen);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] v);
        @(posedge clk);
        bus <= '{1'b1, 1'b0, a, v};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [AW-1:0] a);
        @(posedge clk);
        bus <= '{1'b0, 1'b1, a, 16'h0000};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask : rd
    task automatic wr_rej(input logic [AW-1:0] a, input logic [DW-1:0] v, input logic e);
        wr(a, v);
        step(1);
        check("reject", {15'h0000, rej}, {15'h0000, e});
        wr(REG_REJECT, 16'h0001);
    endtask : wr_rej
    task automatic link(input int k);
        @(posedge clk);
        req <= 3'b001 << k;
        @(posedge clk);
        req <= 3'b000;
        step(3);
    endtask : link
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : give_verdict

    // ==========
    // Scenarios
    initial begin
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        step(1);
        check("safe", safe, 1'b1);
        check("valve", valve, VALVE_CLOSED);
        wr_rej(REG_FLOW_CAL, 16'h0007, 1'b1);
        wr_rej(REG_FLOW_CAL, 16'h0006, 1'b0);
        rd(REG_FLOW_CAL);
        check("fcal", d, 16'h0006);
        rd(4'hF);
        check("unmapped", d, 16'h0000);
        wr_rej(REG_PRESS_APP, 16'h0000, 1'b1);
        wr_rej(REG_PRESS_APP, 16'h0004, 1'b0);
        wr_rej(REG_PRESS_DTYPE, 16'h0003, 1'b1);
        wr_rej(REG_FLOW_DTYPE, 16'h0002, 1'b0);
        wr_rej(REG_OVERRIDE, 16'h0002, 1'b1);
        wr(REG_SAFE_VALUE, 16'h0ABC);
        raw <= 24'sh100000;
        infer <= '{1'b1, DT_REAL, 1'b0, DT_INT, 1'b1, DT_REAL};
        step(3);
        check("press", press, PRESS_SAT_MAX);
        check("app", app, 16'h0004);
        check("fcal", fcal, 16'h0006);
        link(0);
        check("safe", safe, 1'b0);
        check("run", run, 1'b1);
        check("valve", valve, 16'h1234);
        check("pdt", pdt, DT_REAL);
        check("fdt", fdt, DT_REAL);
        check("vdt", vdt, DT_REAL);
        wr_rej(REG_VALVE_DTYPE, 16'h0001, 1'b1);
        check("vdt", vdt, DT_REAL);
        for (int o = 1; o < 6; o++) begin
            wr(REG_OVERRIDE, 16'(o % 5));
            step(3);
            check("override", valve, exp_ovr[o % 5]);
        end
        link(2);
        check("safe", safe, 1'b1);
        check("run", run, 1'b0);
        wr(REG_FULL_SCALE, 16'h7FFF);
        for (int s = 0; s < 4; s++) begin
            wr(REG_SAFE_STATE, 16'(s));
            step(3);
            check("safe state", valve, exp_safe[s]);
        end
        wr(REG_SETPOINT, 16'h0055);
        step(2);
        check("setp", setp, 16'h0000);
        wr(REG_CTRL, 16'h0001);
        wr(REG_SETPOINT, 16'h0055);
        step(2);
        check("setp", setp, 16'h0055);
        @(posedge clk) fault <= 1'b1;
        step(3);
        check("fault", safe, 1'b1);
        rd(REG_STATUS);
        check("status", d, 16'h0006);
        @(posedge clk) fault <= 1'b0;
        wr(REG_CTRL, 16'h0004);
        link(0);
        check("safe", safe, 1'b0);
        link(1);
        check("closed", safe, 1'b1);
        wr(REG_CTRL, 16'h0001);
        step(1);
        check("run", run, 1'b1);
        wr(REG_CTRL, 16'h0002);
        step(1);
        check("stop", safe, 1'b1);
        give_verdict();
    end

    initial begin
        repeat (3000) @(posedge clk);
        num_errors++;
        give_verdict();
    end
endmodule : smvs_tb_top
`default_nettype wire
